/* File: verilog/return_and_rotate_execute.sv */
// Execute sequencer for return-with-literal, return-from-subroutine and rotate-left-through-carry.
`timescale 1ns/100ps
`include "retrot_consts.svh"
module return_and_rotate_execute
	import retrot_pkg::*;
#(
	parameter int PC_W   = 21,
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// Instruction word offered in phase Q1
	input  wire logic [15:0]       instr_word,
	input  wire logic              instr_valid,
	// Configuration
	input  wire logic              xinst_en,
	input  wire logic [ADDR_W-1:0] fsr2_base,
	// Stack
	input  wire logic [PC_W-1:0]   stack_head,
	output logic                   stack_pop,
	output logic                   pc_load,
	output logic [PC_W-1:0]        pc_value,
	// Shadow copies
	input  wire logic [7:0]        shadow_accumulator,
	input  wire logic [7:0]        shadow_flags,
	input  wire logic [3:0]        shadow_bank_pick,
	// File register port
	output logic [ADDR_W-1:0]      file_addr,
	output logic                   file_indexed,
	output logic                   file_rd,
	input  wire logic [7:0]        file_rdata,
	output logic                   file_wr,
	output logic [7:0]             file_wdata,
	// Core state
	output logic [7:0]             w_value,
	output logic [7:0]             status_value,
	output logic [3:0]             bank_pick_register,
	output logic [1:0]             phase,
	output logic                   busy,
	output logic                   flush
);

	// Opcode classification, shared by decode and by any future predecode.
	function automatic op_type op_of(input logic [15:0] word);
		op_type op;
		op = OP_NONE;
		if (word[15:8] == `RET_LIT_UPPER) begin
			op = OP_RET_LIT;
		end else if ((word & `RETURN_MASK) == `RETURN_CODE) begin
			op = OP_RETURN;
		end else if (word[15:12] == `ROT_NIBBLE && word[3:2] == `ROT_SUBCODE) begin
			op = OP_ROTATE;
		end
		return op;
	endfunction

	// Physical file address for an 8-bit operand field.
	// Without the bank register the low half of the access bank maps to bank 0 and the high half to bank F; with ext set, f up to 0x5F is indexed from base instead.
	function automatic logic [ADDR_W:0] map_file(
		input logic [7:0]        f,
		input logic              a,
		input logic              ext,
		input logic [3:0]        bank,
		input logic [ADDR_W-1:0] base
	);
		logic [ADDR_W:0] m;
		m = '0;
		if (a) begin
			m = {1'b0, bank, f};
		end else if (ext && f <= `IDX_LIMIT) begin
			m = {1'b1, ADDR_W'(base + ADDR_W'(f))};
		end else if (f >= `ACC_SPLIT) begin
			m = {1'b0, `ACC_HIGH_BANK, f};
		end else begin
			m = {1'b0, `ACC_LOW_BANK, f};
		end
		return m;
	endfunction

	phase_type         q_r;
	phase_type         q_nxt;
	state_type         state_r;
	state_type         state_nxt;
	op_type            op_r;
	op_type            dec_op;
	logic [15:0]       ir_r;
	logic [7:0]        lit_r;
	logic [7:0]        w_r;
	logic [7:0]        status_r;
	logic [3:0]        bank_r;
	logic [ADDR_W-1:0] addr_r;
	logic              indexed_r;
	logic              rd_r;
	logic              wr_r;
	logic [7:0]        wdata_r;
	logic [7:0]        res_r;
	logic              res_c_r;
	logic              res_n_r;
	logic              res_z_r;
	logic              pop_r;
	logic              pc_load_r;
	logic [PC_W-1:0]   pc_value_r;

	wire logic         take;
	wire logic         take_rot;
	wire logic [ADDR_W:0] dec_map;
	wire logic         at_q1;
	wire logic         at_q2;
	wire logic         at_q3;
	wire logic         at_q4;
	wire logic         is_ret;
	wire logic         dest_file;
	wire logic         restore;

	rotate_link_if #(.DATA_W(8)) rot ();

	rotate_spill_unit #(
		.DATA_W (8)
	) u_rotate (
		.link (rot.unit)
	);

	assign q_nxt     = phase_type'(q_r + 2'h1);
	assign at_q1     = (q_r == PH_Q1);
	assign at_q2     = (q_r == PH_Q2);
	assign at_q3     = (q_r == PH_Q3);
	assign at_q4     = (q_r == PH_Q4);
	assign dec_op    = op_of(instr_word);
	// During the flush cycle the fetched word is stale, so nothing is taken.
	assign take      = at_q1 && state_r == ST_EXEC && instr_valid && dec_op != OP_NONE;
	assign take_rot  = take && dec_op == OP_ROTATE;
	assign dec_map   = map_file(instr_word[`F_MSB:`F_LSB], instr_word[`A_BIT], xinst_en, bank_r, fsr2_base);
	assign is_ret    = (op_r == OP_RET_LIT) || (op_r == OP_RETURN);
	assign dest_file = ir_r[`D_BIT];
	assign restore   = (op_r == OP_RETURN) && ir_r[`S_BIT];

	// The rotate operand is taken straight from the read port in Q3.
	assign rot.operand  = file_rdata;
	assign rot.carry_in = status_r[`FLAG_C];

	// A return holds off the next fetch for one whole cycle while the new address is fetched.
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_EXEC: begin
				if (at_q4 && is_ret) begin
					state_nxt = ST_FLUSH;
				end
			end
			ST_FLUSH: begin
				if (at_q4) begin
					state_nxt = ST_EXEC;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			q_r     <= PH_Q1;
			state_r <= ST_EXEC;
		end else begin
			q_r     <= q_nxt;
			state_r <= state_nxt;
		end
	end

	// Decode in Q1.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			op_r <= OP_NONE;
			ir_r <= 16'h0000;
		end else if (at_q1) begin
			op_r <= take ? dec_op : OP_NONE;
			if (take) begin
				ir_r <= instr_word;
			end
		end else if (at_q4) begin
			// Clearing here lets busy drop as soon as the next Q1 begins.
			op_r <= OP_NONE;
		end
	end

	// Literal read in Q2.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			lit_r <= 8'h00;
		end else if (at_q2 && op_r == OP_RET_LIT) begin
			lit_r <= ir_r[7:0];
		end
	end

	// File read strobe stands through Q2; the address holds until the next rotate.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			addr_r    <= '0;
			indexed_r <= 1'b0;
			rd_r      <= 1'b0;
		end else if (at_q1) begin
			rd_r <= take_rot;
			if (take_rot) begin
				addr_r    <= dec_map[ADDR_W-1:0];
				indexed_r <= dec_map[ADDR_W];
			end
		end else begin
			rd_r <= 1'b0;
		end
	end

	// Process in Q3, stage the write for Q4.
	// The write data is registered at the end of Q3 together with the strobe so that it stands unchanged throughout the Q4 strobe.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			res_r   <= 8'h00;
			res_c_r <= 1'b0;
			res_n_r <= 1'b0;
			res_z_r <= 1'b0;
			wr_r    <= 1'b0;
			wdata_r <= 8'h00;
		end else if (at_q3 && op_r == OP_ROTATE) begin
			res_r   <= rot.result;
			res_c_r <= rot.carry_out;
			res_n_r <= rot.negative;
			res_z_r <= rot.zero;
			wr_r    <= dest_file;
			wdata_r <= rot.result;
		end else begin
			wr_r <= 1'b0;
		end
	end

	// Stack pop and program counter load stand through Q4 of a return.
	// The stack head is captured at the end of Q3 so that pc_value is settled for the whole pulse.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pop_r      <= 1'b0;
			pc_load_r  <= 1'b0;
			pc_value_r <= '0;
		end else if (at_q3 && is_ret) begin
			pop_r      <= 1'b1;
			pc_load_r  <= 1'b1;
			pc_value_r <= stack_head;
		end else begin
			pop_r     <= 1'b0;
			pc_load_r <= 1'b0;
		end
	end

	// Accumulator commit at the end of Q4.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			w_r <= `W_RESET;
		end else if (at_q4) begin
			if (op_r == OP_RET_LIT) begin
				w_r <= lit_r;
			end else if (restore) begin
				w_r <= shadow_accumulator;
			end else if (op_r == OP_ROTATE && !dest_file) begin
				w_r <= res_r;
			end
		end
	end

	// Flags and bank commit at the end of Q4; a plain return leaves them alone.
	// A restore copies the whole flags byte, including bits that this block never computes.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			status_r <= `STATUS_RESET;
			bank_r   <= `BANK_RESET;
		end else if (at_q4) begin
			if (restore) begin
				status_r <= shadow_flags;
				bank_r   <= shadow_bank_pick;
			end else if (op_r == OP_ROTATE) begin
				status_r[`FLAG_C] <= res_c_r;
				status_r[`FLAG_N] <= res_n_r;
				status_r[`FLAG_Z] <= res_z_r;
			end
		end
	end

	// Returns with s clear fall through both commits above untouched.

	assign stack_pop          = pop_r;
	assign pc_load            = pc_load_r;
	assign pc_value           = pc_value_r;
	assign file_addr          = addr_r;
	assign file_indexed       = indexed_r;
	assign file_rd            = rd_r;
	assign file_wr            = wr_r;
	assign file_wdata         = wdata_r;
	assign w_value            = w_r;
	assign status_value       = status_r;
	assign bank_pick_register = bank_r;
	assign phase              = q_r;
	assign busy               = (op_r != OP_NONE) || (state_r == ST_FLUSH);
	assign flush              = (state_r == ST_FLUSH);

endmodule // return_and_rotate_execute

/* File: verilog/retrot_consts.svh */
// Encodings, field positions, reset values and cycle counts for the return and rotate execute block.
//
// Behaviour
// - Return-with-literal is 0x0C upper byte, literal low.
// - Return-with-literal loads accumulator with literal.
// - Return-with-literal pops stack into program counter.
// - Return 0x0012/0x0013 pops stack into program counter.
// - s set restores accumulator, flags, bank from shadows.
// - s clear leaves accumulator, flags, bank alone.
// - Rotate: top nibble 0011, bits 3:2 01.
// - Rotate updates carry, negative and zero flags.
// - d clear writes accumulator, d set writes register.
// - a clear uses access bank, a set uses bank register.
// - a clear, extended set, f up to 0x5F: indexed.
`ifndef RETROT_CONSTS_SVH
`define RETROT_CONSTS_SVH

`define RET_LIT_UPPER   8'h0C
`define RETURN_MASK     16'hFFFE
`define RETURN_CODE     16'h0012
`define ROT_NIBBLE      4'h3
`define ROT_SUBCODE     2'h1
`define F_LSB           4
`define F_MSB           11
`define D_BIT           1
`define A_BIT           0
`define S_BIT           0
`define IDX_LIMIT       8'h5F
`define ACC_SPLIT       8'h80
`define ACC_HIGH_BANK   4'hF
`define ACC_LOW_BANK    4'h0
`define FLAG_C          0
`define FLAG_Z          2
`define FLAG_N          4
`define W_RESET         8'h00
`define STATUS_RESET    8'h00
`define BANK_RESET      4'h0
`define RETURN_CYCLES   2
`define ROTATE_CYCLES   1

`endif

/* File: verilog/retrot_pkg.sv */
// Types shared by the return and rotate execute block.
package retrot_pkg;

	typedef enum logic [1:0] {
		OP_NONE    = 2'b00,
		OP_RET_LIT = 2'b01,
		OP_RETURN  = 2'b10,
		OP_ROTATE  = 2'b11
	} op_type;

	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} phase_type;

	typedef enum logic {
		ST_EXEC  = 1'b0,
		ST_FLUSH = 1'b1
	} state_type;

endpackage

/* File: verilog/rotate_link_if.sv */
// Operand and result signals between the execute sequencer and the rotate datapath.
`timescale 1ns/100ps
interface rotate_link_if #(
	parameter int DATA_W = 8
);
	logic [DATA_W-1:0] operand;
	logic              carry_in;
	logic [DATA_W-1:0] result;
	logic              carry_out;
	logic              negative;
	logic              zero;

	modport unit (input operand, input carry_in, output result, output carry_out, output negative, output zero);
	modport user (output operand, output carry_in, input result, input carry_out, input negative, input zero);
endinterface

/* File: verilog/rotate_spill_unit.sv */
// Combinational rotate-left-through-carry datapath with flag generation.
`timescale 1ns/100ps
module rotate_spill_unit #(
	parameter int DATA_W = 8
) (
	rotate_link_if.unit link
);
	assign link.result    = {link.operand[DATA_W-2:0], link.carry_in};
	assign link.carry_out = link.operand[DATA_W-1];
	assign link.negative  = link.operand[DATA_W-2];
	assign link.zero      = (link.result == '0);
endmodule // rotate_spill_unit

/* File: tb/return_and_rotate_execute_checker.sv */
// Assertions and covers for the return and rotate execute block.
`timescale 1ns/100ps
module return_and_rotate_execute_checker #(
	parameter int PC_W   = 21,
	parameter int ADDR_W = 12
) (
	// Watched ports
	input wire logic            core_clk,
	input wire logic            rst,
	input wire logic [15:0]     instr_word,
	input wire logic            instr_valid,
	input wire logic [PC_W-1:0] stack_head,
	input wire logic            stack_pop,
	input wire logic            pc_load,
	input wire logic [PC_W-1:0] pc_value,
	input wire logic [7:0]      shadow_accumulator,
	input wire logic [3:0]      shadow_bank_pick,
	input wire logic            file_rd,
	input wire logic            file_wr,
	input wire logic [7:0]      w_value,
	input wire logic [3:0]      bank_pick_register,
	input wire logic [1:0]      phase,
	input wire logic            flush
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire take   = phase == 2'h0 && !flush && instr_valid;
	wire rot_go = take && instr_word[15:12] == 4'h3 && instr_word[3:2] == 2'h1;
	wire lit_go = take && instr_word[15:8] == 8'h0C;
	wire ret_go = take && instr_word[15:1] == 15'h0009;
	pop_pairs_a: assert property (stack_pop == pc_load) else $error("pop without load");
	pop_q4_a: assert property (stack_pop |-> phase == 2'h3) else $error("pop outside Q4");
	pop_value_a: assert property (stack_pop |-> pc_value == $past(stack_head)) else $error("bad pc");
	rot_strobes_a: assert property (rot_go |=> file_rd ##2 file_wr == $past(instr_word[1], 3))
		else $error("bad rotate strobes");
	write_q4_a: assert property (file_wr |-> phase == 2'h3) else $error("write outside Q4");
	flush_len_a: assert property ($rose(flush) |-> flush[*4] ##1 !flush) else $error("bad flush");
	lit_load_a: assert property (lit_go |-> ##4 w_value == $past(instr_word[7:0], 4))
		else $error("literal not loaded");
	shadow_load_a: assert property (ret_go && instr_word[0] |-> ##4 w_value == $past(shadow_accumulator)
		&& bank_pick_register == $past(shadow_bank_pick)) else $error("shadow not restored");
	no_restore_a: assert property (ret_go && !instr_word[0] |-> ##4 $stable(w_value)
		&& $stable(bank_pick_register)) else $error("state altered");
	ret_pop_a: assert property (lit_go || ret_go |-> ##3 stack_pop) else $error("no pop");
	cover property (lit_go);
	cover property (ret_go && instr_word[0]);
	cover property (rot_go && instr_word[1]);
endmodule // return_and_rotate_execute_checker

bind return_and_rotate_execute return_and_rotate_execute_checker #(.PC_W(PC_W), .ADDR_W(ADDR_W)) chk_i (
	.core_clk, .rst, .instr_word, .instr_valid, .stack_head, .stack_pop, .pc_load, .pc_value,
	.shadow_accumulator, .shadow_bank_pick, .file_rd, .file_wr, .w_value, .bank_pick_register, .phase, .flush);

/* File: tb/return_and_rotate_execute_tb.sv */
// Directed bench for the return and rotate execute block.
`timescale 1ns/100ps
module return_and_rotate_execute_tb;
	import retrot_pkg::*;
	logic        core_clk, rst, instr_valid, xinst_en, stack_pop, pc_load;
	logic        file_indexed, file_rd, file_wr, busy, flush, rdq, pop, ld, wr, bz;
	logic [15:0] instr_word;
	logic [11:0] fsr2_base, file_addr;
	logic [20:0] stack_head, pc_value, pcv;
	logic [7:0]  shadow_accumulator, shadow_flags, file_rdata, file_wdata, w_value, status_value;
	logic [7:0]  w_e, s_e, r, wd;
	logic [3:0]  shadow_bank_pick, bank_pick_register, b_e;
	logic [1:0]  phase;
	int          fails, total_checks;

	return_and_rotate_execute uut (.core_clk, .rst, .instr_word, .instr_valid, .xinst_en, .fsr2_base,
		.stack_head, .stack_pop, .pc_load, .pc_value, .shadow_accumulator, .shadow_flags, .shadow_bank_pick,
		.file_addr, .file_indexed, .file_rd, .file_rdata, .file_wr, .file_wdata, .w_value, .status_value,
		.bank_pick_register, .phase, .busy, .flush);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task chk(input logic [20:0] g, input logic [20:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task print_verdict;
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Offers a word for the Q1 cycle and samples the strobes in the cycles where they stand.
	task run(input logic [15:0] w, input logic [7:0] rd);
		@(negedge core_clk);
		while (phase !== 2'h3 || flush !== 1'b0) @(negedge core_clk);
		@(posedge core_clk);
		instr_word <= w;
		instr_valid <= 1'b1;
		file_rdata <= rd;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		@(negedge core_clk);
		rdq = file_rd;
		bz = busy;
		repeat (2) @(negedge core_clk);
		pop = stack_pop;
		ld = pc_load;
		wr = file_wr;
		pcv = pc_value;
		wd = file_wdata;
		@(negedge core_clk);
		chk(phase, 2'h0);
		$display("step done word=%h", w);
	endtask

	task ret(input logic [15:0] w, input logic [20:0] sh);
		@(posedge core_clk);
		stack_head <= sh;
		if (w[15:8] == 8'h0C) w_e = w[7:0];
		else if (w[0]) {w_e, s_e, b_e} = {8'hA5, 8'h15, 4'h9};
		run(w, 8'h00);
		chk(pop, 1'b1);
		chk(ld, 1'b1);
		chk(pcv, sh);
		chk(flush, 1'b1);
		chk(bz, 1'b1);
		chk(busy, 1'b1);
		chk(w_value, w_e);
		chk(status_value, s_e);
		chk(bank_pick_register, b_e);
	endtask

	task rot(input logic [15:0] w, input logic [7:0] rd, input logic [11:0] a_e, input logic ix);
		r = {rd[6:0], s_e[0]};
		s_e[0] = rd[7];
		s_e[2] = r == 8'h00;
		s_e[4] = r[7];
		if (!w[1]) w_e = r;
		run(w, rd);
		chk(rdq, 1'b1);
		chk(bz, 1'b1);
		chk(busy, 1'b0);
		chk(file_addr, a_e);
		chk(file_indexed, ix);
		chk(wr, w[1]);
		chk(status_value & 8'h15, s_e & 8'h15);
		chk(w_value, w_e);
		if (w[1]) chk(wd, r);
	endtask

	initial begin
		{rst, instr_word, instr_valid, xinst_en, file_rdata} = {1'b1, 26'h0};
		{fsr2_base, stack_head} = {12'h300, 21'h0};
		{shadow_accumulator, shadow_flags, shadow_bank_pick} = {8'hA5, 8'h15, 4'h9};
		{w_e, s_e, b_e} = 20'h0;
		fails = 0;
		total_checks = 0;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		ret(16'h0C5A, 21'h1ABCD);
		ret(16'h0012, 21'h00246);
		ret(16'h0013, 21'h1FFFE);
		rot(16'h3235, 8'h80, 12'h923, 1'b0);
		rot(16'h3F06, 8'h7F, 12'hFF0, 1'b0);
		@(posedge core_clk);
		xinst_en <= 1'b1;
		rot(16'h35F4, 8'h00, 12'h35F, 1'b1);
		rot(16'h3606, 8'hC3, 12'h060, 1'b0);
		// An undecoded word must leave the read strobe, busy and the accumulator quiet.
		run(16'h3238, 8'h55);
		chk(rdq, 1'b0);
		chk(bz, 1'b0);
		chk(w_value, w_e);
		print_verdict;
	end

	initial begin
		#20000;
		fails++;
		print_verdict;
	end
endmodule // return_and_rotate_execute_tb
